// >>> rtl/sgbd_pkg.sv
package sgbd_pkg;

    // clock and strap sampling timing
    localparam int CLK_HZ         = 200_000_000;
    localparam int SAMPLE_NS      = 1000;
    localparam int SAMPLE_CYC     = (SAMPLE_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int STABLE_SAMPLES = 2;

    // level codes delivered by the strap quantizers
    localparam int LEVEL_W = 3;
    typedef enum logic [2:0] {
        LVL_TIED_LOW  = 3'h0,
        LVL_RES_LOW   = 3'h1,
        LVL_TIED_HIGH = 3'h2,
        LVL_RES_HIGH  = 3'h3,
        LVL_FLOAT     = 3'h4
    } sgbd_level_e;

    // interface mode numbers and their ranges
    localparam logic [3:0] IFM_I2S_FIRST   = 4'h2;
    localparam logic [3:0] IFM_I2S_LAST    = 4'h4;
    localparam logic [3:0] IFM_PCMLO_FIRST = 4'h5;
    localparam logic [3:0] IFM_PCMLO_LAST  = 4'h9;
    localparam logic [3:0] IFM_PCMHI_FIRST = 4'hA;
    localparam logic [3:0] IFM_PCMHI_LAST  = 4'hE;
    typedef enum logic [1:0] {
        IFC_OTHER  = 2'h0,
        IFC_I2S    = 2'h1,
        IFC_PCM_LO = 2'h2,
        IFC_PCM_HI = 2'h3
    } sgbd_ifc_e;

    // gain mode numbers
    localparam logic [2:0] GM_NONE      = 3'h0;
    localparam logic [2:0] GM_TIED_I2S  = 3'h1;
    localparam logic [2:0] GM_TIED_PCM  = 3'h2;
    localparam logic [2:0] GM_RES_LOW   = 3'h3;
    localparam logic [2:0] GM_TIED_HIGH = 3'h4;
    localparam logic [2:0] GM_ALC       = 3'h5;
    localparam logic [2:0] GM_FLOAT     = 3'h6;

    // gain in dB and linear multiplier, unsigned Q3.8
    localparam int         GAIN_MULT_W = 11;
    localparam logic [3:0] DB3         = 4'h3;
    localparam logic [3:0] DB6         = 4'h6;
    localparam logic [3:0] DB9         = 4'h9;
    localparam logic [3:0] DB12        = 4'hC;
    localparam logic [10:0] MULT3      = 11'h169;
    localparam logic [10:0] MULT6      = 11'h200;
    localparam logic [10:0] MULT9      = 11'h2D2;
    localparam logic [10:0] MULT12     = 11'h400;

    // beep modes and level factors, unsigned Q0.10
    localparam int         BEEP_FACTOR_W = 10;
    localparam int         BEEP_AMP_W    = 21;
    localparam logic [2:0] BM_NONE       = 3'h0;
    localparam logic [2:0] BM_OFF        = 3'h1;
    localparam logic [2:0] BM_RES_LOW    = 3'h2;
    localparam logic [2:0] BM_TIED_RAIL  = 3'h3;
    localparam logic [2:0] BM_RES_RAIL   = 3'h4;
    localparam logic [2:0] BM_FLOAT      = 3'h5;
    localparam logic [9:0] BF_RES_LOW    = 10'h2A0;
    localparam logic [9:0] BF_TIED_RAIL  = 10'h230;
    localparam logic [9:0] BF_RES_RAIL   = 10'h1C1;
    localparam logic [9:0] BF_FLOAT      = 10'h150;

    // outcome of the gain decision
    typedef struct packed {
        logic [2:0] mode;
        logic [3:0] db;
        logic       auto_level_control;
        logic       fallback;
    } sgbd_gain_s;

endpackage

// >>> rtl/sgbd_strap_if.sv
`timescale 1ns/1ps
`default_nettype none

// one strap channel between the decoder and its qualifier
interface sgbd_strap_if;
    logic [2:0] rawCode;
    logic       sampleEn;
    logic       clear;
    logic [2:0] code;
    logic       valid;

    modport ctl  (output rawCode, output sampleEn, output clear, input code, input valid);
    modport qual (input rawCode, input sampleEn, input clear, output code, output valid);
endinterface

`default_nettype wire

// >>> rtl/sgbd_strap_qual.sv
`timescale 1ns/1ps
`default_nettype none

module sgbd_strap_qual #(
    parameter int STABLE = sgbd_pkg::STABLE_SAMPLES
) (
    // clock and reset
    input  wire logic  clock,
    input  wire logic  rst_n,
    // strap channel
    sgbd_strap_if.qual sp
);
    generate
        if (STABLE < 2 || STABLE > 8) begin : g_badStable
            $error("STABLE must lie in 2..8");
        end
    endgenerate

    typedef struct packed {
        logic       seen;
        logic [2:0] cand;
        logic [2:0] cnt;
        logic [2:0] code;
        logic       valid;
    } sgbd_qual_s;

    sgbd_qual_s st_q;
    sgbd_qual_s st_d;

    localparam logic [2:0] CNT_LAST = 3'(STABLE - 1);

    // a candidate replaces the held code only after enough equal samples
    always_comb begin
        st_d = st_q;
        if (sp.clear) begin
            st_d = '0;
        end else if (sp.sampleEn) begin
            // cleared candidate is not a sample: a tied-low strap would pass on one look
            if (!st_q.seen || sp.rawCode != st_q.cand) begin
                st_d.seen = 1'b1;
                st_d.cand = sp.rawCode;
                st_d.cnt  = 3'h0;
            end else if (st_q.cnt != CNT_LAST) begin
                st_d.cnt = st_q.cnt + 3'h1;
            end
            if (st_q.seen && sp.rawCode == st_q.cand && st_q.cnt >= CNT_LAST - 3'h1) begin
                st_d.code  = st_q.cand;
                st_d.valid = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sp.code  = st_q.code;
    assign sp.valid = st_q.valid;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    holdCode_a: assert property ((!sp.clear && !(sp.sampleEn && sp.rawCode == st_q.cand))
        |=> $stable(sp.code))
        else $error("held strap code changed without a confirming sample");
    clearDrop_a: assert property (sp.clear |=> !sp.valid)
        else $error("strap code stayed valid through a clear");

endmodule

`default_nettype wire

// >>> rtl/sgbd_decoder.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// - enable high makes the block active; enable low shuts it down.
// - gain strap quantizes into five level codes, each selecting a gain mode.
// - gain strap tied low: 9 dB in I2S modes, 12 dB in modes 10-14.
// - gain strap resistor to ground: fixed 3 dB, valid in modes 2-9.
// - six gain modes: tied high 12 dB, floating 6 dB, others by strap.
// - resistor to supply: 12 dB maximum with clip level control enabled.
// - time slots 4-7: strap tied low, gain fixed at 12 dB.
// - time slots 0-3: every gain except 9 dB selectable.
// - I2S modes accept every strap-selected gain mode.
// - 3/6/9/12 dB map to multipliers 1.41, 2, 2.82, 4; beep scales with it.
// - beep strap gives five codes: one off, four square-wave levels.
// - beep runs only while the enable input is high.
// - beep strap pulled low disables the beep always.
// - beep factors 0.656, 0.547, 0.438, 0.328 times the gain multiplier.
// - interface mode comes from frame syncs; slots 0-3 modes 5-9, 4-7 modes 10-14.
module sgbd_decoder #(
    parameter int SAMPLE_CYCLES = sgbd_pkg::SAMPLE_CYC,
    parameter int STABLE        = sgbd_pkg::STABLE_SAMPLES
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // pins and quantizer outputs, asynchronous
    input  wire logic        ampEnPin,
    input  wire logic [2:0]  gainStrapCode,
    input  wire logic [2:0]  beepStrapCode,
    // interface mode from the serial receiver, same clock
    input  wire logic [3:0]  ifMode,
    // decoded settings
    output logic             ampActive,
    output logic             settingsValid,
    output logic [2:0]       gainMode,
    output logic [3:0]       gainDb,
    output logic [10:0]      gainMultQ,
    output logic             clipAlcEn,
    output logic             comboFallback,
    output logic             beepOn,
    output logic [2:0]       beepMode,
    output logic [20:0]      beepAmpQ
);
    generate
        if (SAMPLE_CYCLES < 1 || SAMPLE_CYCLES > 256) begin : g_badDiv
            $error("SAMPLE_CYCLES must lie in 1..256");
        end
    endgenerate

    localparam logic [7:0] DIV_LAST = 8'(SAMPLE_CYCLES - 1);

    typedef struct packed {
        logic        enMeta;
        logic        enSync;
        logic [2:0]  gainMeta;
        logic [2:0]  gainSync;
        logic [2:0]  beepMeta;
        logic [2:0]  beepSync;
        logic [7:0]  divCnt;
        logic        sampleEn;
        logic        active;
        logic        valid;
        logic [2:0]  gainMode;
        logic [3:0]  gainDb;
        logic [10:0] gainMult;
        logic        auto_level_control;
        logic        fallback;
        logic        beepOn;
        logic [2:0]  beepMode;
        logic [20:0] beepAmp;
    } sgbd_dec_s;

    sgbd_dec_s st_q;
    sgbd_dec_s st_d;

    sgbd_strap_if gainQ ();
    sgbd_strap_if beepQ ();

    // sort the interface mode into the classes the gain check needs
    function automatic sgbd_pkg::sgbd_ifc_e classify(input logic [3:0] m);
        if (m >= sgbd_pkg::IFM_PCMHI_FIRST && m <= sgbd_pkg::IFM_PCMHI_LAST) begin
            classify = sgbd_pkg::IFC_PCM_HI;
        end else if (m >= sgbd_pkg::IFM_PCMLO_FIRST && m <= sgbd_pkg::IFM_PCMLO_LAST) begin
            classify = sgbd_pkg::IFC_PCM_LO;
        end else if (m >= sgbd_pkg::IFM_I2S_FIRST && m <= sgbd_pkg::IFM_I2S_LAST) begin
            classify = sgbd_pkg::IFC_I2S;
        end else begin
            classify = sgbd_pkg::IFC_OTHER;
        end
    endfunction

    // gain dB to linear multiplier
    function automatic logic [10:0] multOf(input logic [3:0] db);
        case (db)
            sgbd_pkg::DB3:  multOf = sgbd_pkg::MULT3;
            sgbd_pkg::DB6:  multOf = sgbd_pkg::MULT6;
            sgbd_pkg::DB9:  multOf = sgbd_pkg::MULT9;
            sgbd_pkg::DB12: multOf = sgbd_pkg::MULT12;
            default:        multOf = 11'h000;
        endcase
    endfunction

    // beep mode to level factor, zero when silent
    function automatic logic [9:0] factorOf(input logic [2:0] bm);
        case (bm)
            sgbd_pkg::BM_RES_LOW:   factorOf = sgbd_pkg::BF_RES_LOW;
            sgbd_pkg::BM_TIED_RAIL: factorOf = sgbd_pkg::BF_TIED_RAIL;
            sgbd_pkg::BM_RES_RAIL:  factorOf = sgbd_pkg::BF_RES_RAIL;
            sgbd_pkg::BM_FLOAT:     factorOf = sgbd_pkg::BF_FLOAT;
            default:                factorOf = 10'h000;
        endcase
    endfunction

    // strap code plus interface class to gain; time slots 4-7 force 12 dB
    function automatic sgbd_pkg::sgbd_gain_s decodeGain(input logic [2:0] code,
                                                        input sgbd_pkg::sgbd_ifc_e ifc);
        sgbd_pkg::sgbd_gain_s g;
        g = '0;
        if (ifc == sgbd_pkg::IFC_PCM_HI) begin
            g.mode     = sgbd_pkg::GM_TIED_PCM;
            g.db       = sgbd_pkg::DB12;
            g.fallback = (code != sgbd_pkg::LVL_TIED_LOW);
        end else begin
            case (code)
                sgbd_pkg::LVL_TIED_LOW: begin
                    if (ifc == sgbd_pkg::IFC_PCM_LO) begin
                        g.mode     = sgbd_pkg::GM_FLOAT;
                        g.db       = sgbd_pkg::DB6;
                        g.fallback = 1'b1;
                    end else begin
                        g.mode = sgbd_pkg::GM_TIED_I2S;
                        g.db   = sgbd_pkg::DB9;
                    end
                end
                sgbd_pkg::LVL_RES_LOW: begin
                    g.mode = sgbd_pkg::GM_RES_LOW;
                    g.db   = sgbd_pkg::DB3;
                end
                sgbd_pkg::LVL_TIED_HIGH: begin
                    g.mode = sgbd_pkg::GM_TIED_HIGH;
                    g.db   = sgbd_pkg::DB12;
                end
                sgbd_pkg::LVL_RES_HIGH: begin
                    g.mode = sgbd_pkg::GM_ALC;
                    g.db   = sgbd_pkg::DB12;
                    g.auto_level_control  = 1'b1;
                end
                default: begin
                    g.mode = sgbd_pkg::GM_FLOAT; // floating, also unused codes
                    g.db   = sgbd_pkg::DB6;
                end
            endcase
        end
        decodeGain = g;
    endfunction

    // beep strap code to beep mode number
    function automatic logic [2:0] beepModeOf(input logic [2:0] code);
        case (code)
            sgbd_pkg::LVL_TIED_LOW:  beepModeOf = sgbd_pkg::BM_OFF;
            sgbd_pkg::LVL_RES_LOW:   beepModeOf = sgbd_pkg::BM_RES_LOW;
            sgbd_pkg::LVL_TIED_HIGH: beepModeOf = sgbd_pkg::BM_TIED_RAIL;
            sgbd_pkg::LVL_RES_HIGH:  beepModeOf = sgbd_pkg::BM_RES_RAIL;
            default:                 beepModeOf = sgbd_pkg::BM_FLOAT;
        endcase
    endfunction

    // qualifier channels: cleared whenever the block is not active
    assign gainQ.rawCode  = st_q.gainSync;
    assign gainQ.sampleEn = st_q.sampleEn;
    assign gainQ.clear    = !st_q.active;
    assign beepQ.rawCode  = st_q.beepSync;
    assign beepQ.sampleEn = st_q.sampleEn;
    assign beepQ.clear    = !st_q.active;

    sgbd_strap_qual #(.STABLE(STABLE)) u_gainQual (
        .clock (clock),
        .rst_n (rst_n),
        .sp    (gainQ)
    );

    sgbd_strap_qual #(.STABLE(STABLE)) u_beepQual (
        .clock (clock),
        .rst_n (rst_n),
        .sp    (beepQ)
    );

    // next state: synchronisers, sample divider, decoded settings
    always_comb begin
        sgbd_pkg::sgbd_gain_s gSel;
        logic [2:0]           bm;
        gSel = '0;
        bm   = '0;
        st_d = st_q;
        st_d.enMeta   = ampEnPin;
        st_d.enSync   = st_q.enMeta;
        st_d.gainMeta = gainStrapCode;
        st_d.gainSync = st_q.gainMeta;
        st_d.beepMeta = beepStrapCode;
        st_d.beepSync = st_q.beepMeta;
        st_d.active   = st_q.enSync;
        st_d.sampleEn = 1'b0;
        if (!st_q.enSync || !st_q.active) begin
            // shutdown drops settings and beep in the same edge as active
            st_d.divCnt   = 8'h00;
            st_d.valid    = 1'b0;
            st_d.gainMode = sgbd_pkg::GM_NONE;
            st_d.gainDb   = 4'h0;
            st_d.gainMult = 11'h000;
            st_d.auto_level_control      = 1'b0;
            st_d.fallback = 1'b0;
            st_d.beepOn   = 1'b0;
            st_d.beepMode = sgbd_pkg::BM_NONE;
            st_d.beepAmp  = 21'h00_0000;
        end else begin
            if (st_q.divCnt == DIV_LAST) begin
                st_d.divCnt   = 8'h00;
                st_d.sampleEn = 1'b1;
            end else begin
                st_d.divCnt = st_q.divCnt + 8'h01;
            end
            // settings follow only qualified codes, so they hold between changes
            if (gainQ.valid && beepQ.valid) begin
                gSel          = decodeGain(gainQ.code, classify(ifMode));
                bm            = beepModeOf(beepQ.code);
                st_d.valid    = 1'b1;
                st_d.gainMode = gSel.mode;
                st_d.gainDb   = gSel.db;
                st_d.gainMult = multOf(gSel.db);
                st_d.auto_level_control      = gSel.auto_level_control;
                st_d.fallback = gSel.fallback;
                st_d.beepMode = bm;
                st_d.beepOn   = (bm != sgbd_pkg::BM_OFF);
                st_d.beepAmp  = {10'h000, multOf(gSel.db)} * {11'h000, factorOf(bm)};
            end
        end
    end

    // state register, synchronous reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign ampActive     = st_q.active;
    assign settingsValid = st_q.valid;
    assign gainMode      = st_q.gainMode;
    assign gainDb        = st_q.gainDb;
    assign gainMultQ     = st_q.gainMult;
    assign clipAlcEn     = st_q.auto_level_control;
    assign comboFallback = st_q.fallback;
    assign beepOn        = st_q.beepOn;
    assign beepMode      = st_q.beepMode;
    assign beepAmpQ      = st_q.beepAmp;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    wire logic qualOk = st_q.active && st_q.enSync && gainQ.valid && beepQ.valid;

    enRise_a: assert property (ampEnPin [*3] |=> ampActive)
        else $error("active did not follow a held enable");
    enFall_a: assert property (!ampEnPin [*3] |=> !ampActive && !settingsValid)
        else $error("block stayed active with enable low");
    slotHigh_a: assert property ((qualOk && classify(ifMode) == sgbd_pkg::IFC_PCM_HI)
        |=> gainDb == sgbd_pkg::DB12 && gainMode == sgbd_pkg::GM_TIED_PCM)
        else $error("slots 4-7 did not force 12 dB");
    noNine_a: assert property ((qualOk && classify(ifMode) == sgbd_pkg::IFC_PCM_LO)
        |=> gainDb != sgbd_pkg::DB9)
        else $error("9 dB applied in slots 0-3");
    tiedI2s_a: assert property ((qualOk && classify(ifMode) == sgbd_pkg::IFC_I2S
        && gainQ.code == sgbd_pkg::LVL_TIED_LOW) |=> gainDb == sgbd_pkg::DB9 && !comboFallback)
        else $error("tied-low strap in I2S did not give 9 dB");
    alcGain_a: assert property (clipAlcEn |-> gainDb == sgbd_pkg::DB12 && gainMode == sgbd_pkg::GM_ALC)
        else $error("clip level control on outside its gain mode");
    multMap_a: assert property (settingsValid |-> gainMultQ == multOf(gainDb) && gainMultQ != 11'h000)
        else $error("gain multiplier does not match gain");
    beepEn_a: assert property (beepOn |-> ampActive && beepMode != sgbd_pkg::BM_OFF)
        else $error("beep on while disabled or strapped low");
    beepLow_a: assert property ((qualOk && beepQ.code == sgbd_pkg::LVL_TIED_LOW) |=> !beepOn)
        else $error("beep ran with strap pulled low");
    beepAmp_a: assert property (beepOn |-> beepAmpQ == {10'h000, gainMultQ} * {11'h000, factorOf(beepMode)})
        else $error("beep level is not factor times multiplier");

    alcSeen_c: cover property (clipAlcEn);
    fallbackSeen_c: cover property (comboFallback);
    beepSeen_c: cover property (beepOn && gainDb == sgbd_pkg::DB12);
    shutdownSeen_c: cover property (settingsValid ##1 !ampActive);

endmodule

`default_nettype wire

// >>> tb/sgbd_strap_host.sv
`timescale 1ns/1ps
`default_nettype none

// host side of the straps: fixed resistors plus one tri-state beep GPIO
module sgbd_strap_host (
    // strap population and GPIO state
    input  wire logic [2:0] gainPop,
    input  wire logic       slotHi,
    input  wire logic       misStrap,
    input  wire logic [1:0] beepGpio,
    input  wire logic [2:0] beepPop,
    // quantized strap levels
    output logic      [2:0] gainStrapCode,
    output logic      [2:0] beepStrapCode
);
    // upper slots need a grounded gain strap; misStrap breaks that on purpose
    assign gainStrapCode = (slotHi && !misStrap) ? 3'h0 : gainPop;

    // gpio low silences, high ties to the rail, tristate leaves the resistor
    always_comb begin
        case (beepGpio)
            2'h0:    beepStrapCode = 3'h0;
            2'h1:    beepStrapCode = 3'h2;
            default: beepStrapCode = beepPop;
        endcase
    end
endmodule

`default_nettype wire

// >>> tb/sgbd_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none

module sgbd_decoder_tb;
    localparam int SAMP = 4;
    typedef struct packed {
        logic [2:0] lvl;
        logic [3:0] ifm;
        logic       ms;
        logic [1:0] gpio;
        logic [2:0] pop;
        logic [2:0] gm;
        logic [3:0] db;
        logic       fb;
        logic [2:0] bm;
    } sgbd_row_s;
    // strap level, mode, gpio, population beside the expected decode
    localparam sgbd_row_s ROWS [10] = '{
        '{3'h0, 4'h2, 1'b0, 2'h2, 3'h1, 3'h1, 4'h9, 1'b0, 3'h2},
        '{3'h0, 4'hC, 1'b0, 2'h1, 3'h4, 3'h2, 4'hC, 1'b0, 3'h3},
        '{3'h1, 4'h5, 1'b0, 2'h2, 3'h3, 3'h3, 4'h3, 1'b0, 3'h4},
        '{3'h2, 4'h9, 1'b0, 2'h2, 3'h4, 3'h4, 4'hC, 1'b0, 3'h5},
        '{3'h3, 4'h3, 1'b0, 2'h0, 3'h4, 3'h5, 4'hC, 1'b0, 3'h1},
        '{3'h4, 4'h4, 1'b0, 2'h2, 3'h7, 3'h6, 4'h6, 1'b0, 3'h5},
        '{3'h0, 4'h7, 1'b0, 2'h2, 3'h1, 3'h6, 4'h6, 1'b1, 3'h2},
        '{3'h4, 4'hE, 1'b1, 2'h1, 3'h4, 3'h2, 4'hC, 1'b1, 3'h3},
        '{3'h0, 4'h1, 1'b0, 2'h2, 3'h4, 3'h1, 4'h9, 1'b0, 3'h5},
        '{3'h5, 4'h1, 1'b0, 2'h2, 3'h2, 3'h6, 4'h6, 1'b0, 3'h3}};

    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        ampEnPin = 1'b0;
    logic [3:0]  ifMode = 4'h2;
    logic [2:0]  gainPop = 3'h0;
    logic        misStrap = 1'b0;
    logic [1:0]  beepGpio = 2'h2;
    logic [2:0]  beepPop = 3'h4;
    logic [2:0]  gainStrapCode;
    logic [2:0]  beepStrapCode;
    logic        ampActive;
    logic        settingsValid;
    logic [2:0]  gainMode;
    logic [3:0]  gainDb;
    logic [10:0] gainMultQ;
    logic        clipAlcEn;
    logic        comboFallback;
    logic        beepOn;
    logic [2:0]  beepMode;
    logic [20:0] beepAmpQ;
    int          n_fail = 0;
    int          n_tests = 0;

    // 200 MHz clock
    always #2.5 clock = ~clock;

    sgbd_strap_host u_sgbd_strap_host (
        .gainPop(gainPop), .slotHi(ifMode >= 4'hA), .misStrap(misStrap), .beepGpio(beepGpio),
        .beepPop(beepPop), .gainStrapCode(gainStrapCode), .beepStrapCode(beepStrapCode));

    // short sample period keeps each settle around a dozen cycles
    sgbd_decoder #(.SAMPLE_CYCLES(SAMP), .STABLE(2)) u_sgbd_decoder (
        .clock(clock), .rst_n(rst_n), .ampEnPin(ampEnPin), .gainStrapCode(gainStrapCode),
        .beepStrapCode(beepStrapCode), .ifMode(ifMode), .ampActive(ampActive),
        .settingsValid(settingsValid), .gainMode(gainMode), .gainDb(gainDb), .gainMultQ(gainMultQ),
        .clipAlcEn(clipAlcEn), .comboFallback(comboFallback), .beepOn(beepOn), .beepMode(beepMode),
        .beepAmpQ(beepAmpQ));

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // inputs always move 1 ns after the edge
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic chk(input string nm, input logic [20:0] exp, input logic [20:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    function automatic logic [10:0] mult_of(input logic [3:0] db);
        case (db)
            4'h3:    return sgbd_pkg::MULT3;
            4'h6:    return sgbd_pkg::MULT6;
            4'h9:    return sgbd_pkg::MULT9;
            4'hC:    return sgbd_pkg::MULT12;
            default: return 11'h0;
        endcase
    endfunction

    function automatic logic [9:0] factor_of(input logic [2:0] bm);
        case (bm)
            3'h2:    return sgbd_pkg::BF_RES_LOW;
            3'h3:    return sgbd_pkg::BF_TIED_RAIL;
            3'h4:    return sgbd_pkg::BF_RES_RAIL;
            3'h5:    return sgbd_pkg::BF_FLOAT;
            default: return 10'h0;
        endcase
    endfunction

    // bounded wait; a missing answer is a mismatch, not a hang
    task automatic wait_valid();
        int i;
        i = 0;
        while (settingsValid !== 1'b1 && i < 60) begin
            step(1);
            i++;
        end
        chk("settingsValid", 21'h1, 21'(settingsValid));
    endtask

    task automatic check_all(input logic [2:0] gm, input logic [3:0] db, input logic fb, input logic [2:0] bm);
        chk("ampActive", 21'h1, 21'(ampActive));
        chk("gainMode", 21'(gm), 21'(gainMode));
        chk("gainDb", 21'(db), 21'(gainDb));
        chk("gainMultQ", 21'(mult_of(db)), 21'(gainMultQ));
        chk("clipAlcEn", 21'(gm == 3'h5), 21'(clipAlcEn));
        chk("comboFallback", 21'(fb), 21'(comboFallback));
        chk("beepMode", 21'(bm), 21'(beepMode));
        chk("beepOn", 21'(bm != 3'h1), 21'(beepOn));
        chk("beepAmpQ", 21'(mult_of(db)) * 21'(factor_of(bm)), beepAmpQ);
    endtask

    // watchdog, far beyond the expected several hundred cycles
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        $display("CHECK FAILED watchdog expected finish seen timeout");
        complete_run();
    end

    initial begin
        step(12);
        chk("resetActive", 21'h0, 21'(ampActive));
        chk("resetBeepAmp", 21'h0, beepAmpQ);
        rst_n = 1'b1;
        // ordinary decodes, one enable cycle per row
        foreach (ROWS[r]) begin
            // host quiets the tone and lets it settle before dropping enable
            beepGpio = 2'h0;
            step(6 * SAMP);
            chk("beepQuiet", 21'h0, 21'(beepOn));
            ampEnPin = 1'b0;
            step(4);
            gainPop = ROWS[r].lvl;
            ifMode = ROWS[r].ifm;
            misStrap = ROWS[r].ms;
            beepGpio = ROWS[r].gpio;
            beepPop = ROWS[r].pop;
            step(4);
            ampEnPin = 1'b1;
            wait_valid();
            check_all(ROWS[r].gm, ROWS[r].db, ROWS[r].fb, ROWS[r].bm);
        end
        // enable latency and shutdown
        ampEnPin = 1'b0;
        step(6);
        chk("ampActiveOff", 21'h0, 21'(ampActive));
        chk("beepOnOff", 21'h0, 21'(beepOn));
        gainPop = 3'h0;
        ifMode = 4'h2;
        misStrap = 1'b0;
        beepGpio = 2'h2;
        beepPop = 3'h1;
        ampEnPin = 1'b1;
        step(2);
        chk("ampActiveEarly", 21'h0, 21'(ampActive));
        step(1);
        chk("ampActiveOn", 21'h1, 21'(ampActive));
        wait_valid();
        check_all(3'h1, 4'h9, 1'b0, 3'h2);
        // mode change while valid: re-decoded at once
        ifMode = 4'hC;
        step(2);
        check_all(3'h2, 4'hC, 1'b0, 3'h2);
        ifMode = 4'h6;
        step(2);
        check_all(3'h6, 4'h6, 1'b1, 3'h2);
        ifMode = 4'h2;
        // one-cycle glitch ignored, lasting change taken
        gainPop = 3'h2;
        step(1);
        gainPop = 3'h0;
        step(6 * SAMP);
        check_all(3'h1, 4'h9, 1'b0, 3'h2);
        gainPop = 3'h2;
        step(6 * SAMP);
        check_all(3'h4, 4'hC, 1'b0, 3'h2);
        // host gpio silences and re-enables the tone
        beepGpio = 2'h0;
        step(6 * SAMP);
        check_all(3'h4, 4'hC, 1'b0, 3'h1);
        beepGpio = 2'h1;
        step(6 * SAMP);
        check_all(3'h4, 4'hC, 1'b0, 3'h3);
        // enable falls with the tone running
        ampEnPin = 1'b0;
        step(2);
        chk("beepOnHeld", 21'h1, 21'(beepOn));
        step(1);
        chk("beepOnDrop", 21'h0, 21'(beepOn));
        chk("settingsDrop", 21'h0, 21'(settingsValid));
        // reset in mid-run, then recovery
        ampEnPin = 1'b1;
        wait_valid();
        rst_n = 1'b0;
        step(2);
        chk("midResetValid", 21'h0, 21'(settingsValid));
        chk("midResetGain", 21'h0, 21'(gainDb));
        rst_n = 1'b1;
        wait_valid();
        check_all(3'h4, 4'hC, 1'b0, 3'h3);
        complete_run();
    end
endmodule

`default_nettype wire
